// [inc/rsisc_regs.svh]
// Connector map and reset values of the run/stop scan controller
`ifndef RSISC_REGS_SVH
`define RSISC_REGS_SVH

// Digital connector indices
`define RSISC_CONN_ZERO   8'h00
`define RSISC_CONN_ONE    8'h01
`define RSISC_CONN_UNUSED 8'h02
`define RSISC_CONN_IN     8'h10
`define RSISC_CONN_KEY    8'h28
`define RSISC_CONN_Q      8'h30
`define RSISC_CONN_Q_END  8'h3F
`define RSISC_CONN_M      8'h40
`define RSISC_CONN_M_END  8'h57
`define RSISC_CONN_S      8'h58
`define RSISC_CONN_BLANK  8'h60
`define RSISC_CONN_BLK    8'h80

// Analog connector indices
`define RSISC_ANA_AI      4'h0
`define RSISC_ANA_AQ      4'h8
`define RSISC_ANA_AM      4'hA

// Reset values
`define RSISC_OUT_RST     16'h0000
`define RSISC_FLAG_RST    24'h00_0000
`define RSISC_SHIFT_RST   8'h00

`endif

// [inc/rsisc_pkg.sv]
// Types and sizes of the run/stop scan controller
package rsisc_pkg;

  localparam int RSISC_N_DIN = 24;
  localparam int RSISC_N_KEY = 4;
  localparam int RSISC_N_AI  = 8;
  localparam int RSISC_N_Q   = 16;
  localparam int RSISC_N_AQ  = 2;
  localparam int RSISC_N_M   = 24;
  localparam int RSISC_N_AM  = 6;
  localparam int RSISC_N_S   = 8;
  localparam int RSISC_N_BLK = 32;
  localparam int RSISC_PIN_W = RSISC_N_DIN + RSISC_N_KEY;

  typedef logic [9:0] rsisc_ana_t;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_AND,
    OP_OR,
    OP_NAND,
    OP_NOR,
    OP_XOR,
    OP_NOT,
    OP_SHIFT,
    OP_ACMP,
    OP_AMOV
  } rsisc_op_t;

  typedef struct packed {
    rsisc_op_t  op;
    logic [7:0] dst;
    logic [7:0] in3;
    logic [7:0] in2;
    logic [7:0] in1;
    logic [7:0] in0;
  } rsisc_blk_t;

  typedef enum logic [1:0] {
    ST_STOP,
    ST_SAMPLE,
    ST_EVAL,
    ST_UPDATE
  } rsisc_state_t;

endpackage

// [inc/rsisc_pin_if.sv]
// Raw and debounced input terminal levels
`timescale 1ns/10ps
`default_nettype none

interface rsisc_pin_if;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] raw;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] level;

  modport src (output raw, input level);
  modport flt (input raw, output level);
endinterface

`default_nettype wire

// [logic/rsisc_in_filter.sv]
// Three-stage synchroniser and agreement filter for input terminals
`timescale 1ns/10ps
`default_nettype none

module rsisc_in_filter (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Terminal levels
  rsisc_pin_if.flt        pins
);

  logic [rsisc_pkg::RSISC_PIN_W-1:0] s1_r;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] s2_r;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] s3_r;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] lvl_r;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] s1_nxt;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] s2_nxt;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] s3_nxt;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] lvl_nxt;
  logic [rsisc_pkg::RSISC_PIN_W-1:0] agree;

  always_comb
  begin
    s1_nxt  = pins.raw;
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    agree   = ~(s2_r ^ s3_r);
    // A level counts only once two late stages agree
    lvl_nxt = (agree & s3_r) | (~agree & lvl_r);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end
    else
    begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign pins.level = lvl_r;

endmodule

`default_nettype wire

// [logic/rsisc_top.sv]
// Run/stop scan controller: input image, block evaluator and output image
//
// Functional notes
// - Stop state freezes the input image
// - Stop state never evaluates program blocks
// - Stop state forces every output off
// - Run state samples all inputs every scan
// - Run state evaluates program then drives outputs
// - Red indicator stopped, green indicator running
// - Expansion points numbered in installation order
// - Connector space holds all input, output, flag kinds
// - Terminals seven, eight read digital and analog
// - Voltage present reads one, absent reads zero
// - Constant one and constant zero connectors
// - Unused block inputs take a neutral level
// - Stored program present: power-up goes to run
`timescale 1ns/10ps
`default_nettype none
`include "rsisc_regs.svh"

module rsisc_top (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // Input terminals, base unit then expansion modules in installation order
  input  wire logic [7:0]                      base_in_pin,
  input  wire logic [15:0]                     exp_in_pin,
  input  wire logic [3:0]                      cursor_key_pin,
  // Converter words on the core clock
  input  wire rsisc_pkg::rsisc_ana_t [1:0]     base_ai,
  input  wire rsisc_pkg::rsisc_ana_t [5:0]     exp_ai,
  // Mode control
  input  wire logic                            program_present,
  input  wire logic                            start_req,
  input  wire logic                            stop_req,
  // Program load: block writes taken in stop only, prog_len read every scan
  input  wire logic                            prog_we,
  input  wire logic [4:0]                      prog_addr,
  input  wire rsisc_pkg::rsisc_blk_t           prog_word,
  input  wire logic [5:0]                      prog_len,
  // Field outputs and indication
  output logic [15:0]                          field_out,
  output rsisc_pkg::rsisc_ana_t [1:0]          analog_out,
  output logic                                 led_red,
  output logic                                 led_green,
  output logic                                 scan_pulse
);

  // Picks a digital connector, substituting the neutral level for unused
  function automatic logic pick(input logic [255:0] v, input logic [7:0] sel, input logic nb);
    logic r;
    if (sel == `RSISC_CONN_UNUSED)
      r = nb;
    else
      r = v[sel];
    return r;
  endfunction

  rsisc_pin_if pin_if ();

  // Scan state
  rsisc_pkg::rsisc_state_t                     state_r;
  rsisc_pkg::rsisc_state_t                     state_nxt;
  logic                                        boot_r;
  logic                                        boot_nxt;
  logic                                        run_r;
  logic                                        run_nxt;
  logic                                        pulse_r;
  logic                                        pulse_nxt;
  logic [5:0]                                  idx_r;
  logic [5:0]                                  idx_nxt;

  // Images
  logic [23:0]                                 din_img_r;
  logic [23:0]                                 din_img_nxt;
  logic [3:0]                                  key_img_r;
  logic [3:0]                                  key_img_nxt;
  rsisc_pkg::rsisc_ana_t [7:0]                 ai_img_r;
  rsisc_pkg::rsisc_ana_t [7:0]                 ai_img_nxt;
  logic [15:0]                                 out_r;
  logic [15:0]                                 out_nxt;
  rsisc_pkg::rsisc_ana_t [1:0]                 aq_out_r;
  rsisc_pkg::rsisc_ana_t [1:0]                 aq_out_nxt;

  // Program working state
  logic [15:0]                                 q_r;
  logic [15:0]                                 q_nxt;
  logic [23:0]                                 m_r;
  logic [23:0]                                 m_nxt;
  logic [7:0]                                  s_r;
  logic [7:0]                                  s_nxt;
  logic [31:0]                                 b_r;
  logic [31:0]                                 b_nxt;
  rsisc_pkg::rsisc_ana_t [5:0]                 am_r;
  rsisc_pkg::rsisc_ana_t [5:0]                 am_nxt;
  rsisc_pkg::rsisc_ana_t [1:0]                 aq_r;
  rsisc_pkg::rsisc_ana_t [1:0]                 aq_nxt;

  // Program store
  rsisc_pkg::rsisc_blk_t [31:0]                prog_r;
  rsisc_pkg::rsisc_blk_t [31:0]                prog_nxt;

  // Evaluation
  rsisc_pkg::rsisc_blk_t                       cur;
  logic [255:0]                                conn_vec;
  rsisc_pkg::rsisc_ana_t [15:0]                ana_vec;
  logic                                        nb;
  logic                                        a0;
  logic                                        a1;
  logic                                        a2;
  logic                                        a3;
  logic                                        res;
  logic                                        last_blk;

  // Expansion points follow base points in installation order
  assign pin_if.raw = {cursor_key_pin, exp_in_pin, base_in_pin};

  rsisc_in_filter u_in_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .pins     (pin_if.flt)
  );

  // Connector space seen by the program
  always_comb
  begin
    conn_vec                              = '0;
    conn_vec[`RSISC_CONN_ZERO]            = 1'b0;
    conn_vec[`RSISC_CONN_ONE]             = 1'b1;
    conn_vec[`RSISC_CONN_IN +: 24]        = din_img_r;
    conn_vec[`RSISC_CONN_KEY +: 4]        = key_img_r;
    conn_vec[`RSISC_CONN_Q +: 16]         = q_r;
    conn_vec[`RSISC_CONN_M +: 24]         = m_r;
    conn_vec[`RSISC_CONN_S +: 8]          = s_r;
    conn_vec[`RSISC_CONN_BLK +: 32]       = b_r;
    // Analog view of terminals seven and eight sits at the first two slots
    ana_vec                               = {am_r, aq_r, ai_img_r};
  end

  // Current block and its result
  always_comb
  begin
    cur = prog_r[idx_r[4:0]];
    nb  = (cur.op == rsisc_pkg::OP_AND) || (cur.op == rsisc_pkg::OP_NAND);
    a0  = pick(conn_vec, cur.in0, nb);
    a1  = pick(conn_vec, cur.in1, nb);
    a2  = pick(conn_vec, cur.in2, nb);
    a3  = pick(conn_vec, cur.in3, nb);
    case (cur.op)
      rsisc_pkg::OP_AND:   res = a0 & a1 & a2 & a3;
      rsisc_pkg::OP_OR:    res = a0 | a1 | a2 | a3;
      rsisc_pkg::OP_NAND:  res = ~(a0 & a1 & a2 & a3);
      rsisc_pkg::OP_NOR:   res = ~(a0 | a1 | a2 | a3);
      rsisc_pkg::OP_XOR:   res = a0 ^ a1 ^ a2 ^ a3;
      rsisc_pkg::OP_NOT:   res = ~a0;
      rsisc_pkg::OP_SHIFT: res = s_r[7];
      rsisc_pkg::OP_ACMP:  res = ana_vec[cur.in0[3:0]] > ana_vec[cur.in1[3:0]];
      default:             res = 1'b0;
    endcase
    last_blk = (idx_r >= prog_len) || (idx_r == 6'h20);
  end

  // Program store, writable only while stopped
  always_comb
  begin
    prog_nxt = prog_r;
    if (prog_we && (state_r == rsisc_pkg::ST_STOP))
      prog_nxt[prog_addr] = prog_word;
  end

  // Scan sequencer and program working state
  always_comb
  begin
    state_nxt   = state_r;
    boot_nxt    = 1'b0;
    pulse_nxt   = 1'b0;
    idx_nxt     = idx_r;
    din_img_nxt = din_img_r;
    key_img_nxt = key_img_r;
    ai_img_nxt  = ai_img_r;
    out_nxt     = out_r;
    aq_out_nxt  = aq_out_r;
    q_nxt       = q_r;
    m_nxt       = m_r;
    s_nxt       = s_r;
    b_nxt       = b_r;
    am_nxt      = am_r;
    aq_nxt      = aq_r;
    case (state_r)
      rsisc_pkg::ST_STOP:
      begin
        // Images hold, nothing is evaluated, outputs stay off
        out_nxt    = `RSISC_OUT_RST;
        aq_out_nxt = '0;
        if (program_present && (boot_r || start_req) && !stop_req)
          state_nxt = rsisc_pkg::ST_SAMPLE;
      end
      rsisc_pkg::ST_SAMPLE:
      begin
        // A terminal with voltage reads one
        din_img_nxt = pin_if.level[23:0];
        key_img_nxt = pin_if.level[27:24];
        ai_img_nxt  = {exp_ai, base_ai};
        idx_nxt     = 6'h00;
        state_nxt   = rsisc_pkg::ST_EVAL;
      end
      rsisc_pkg::ST_EVAL:
      begin
        if (last_blk)
          state_nxt = rsisc_pkg::ST_UPDATE;
        else
        begin
          idx_nxt = idx_r + 6'h01;
          b_nxt[idx_r[4:0]] = res;
          if (cur.op == rsisc_pkg::OP_AMOV)
          begin
            if (cur.dst[3:0] >= `RSISC_ANA_AM)
              am_nxt[cur.dst[3:0] - `RSISC_ANA_AM] = ana_vec[cur.in0[3:0]];
            else if (cur.dst[3:0] >= `RSISC_ANA_AQ)
              aq_nxt[cur.dst[0]] = ana_vec[cur.in0[3:0]];
          end
          else
          begin
            if ((cur.op == rsisc_pkg::OP_SHIFT) && a1)
              s_nxt = {s_r[6:0], a0};
            if ((cur.dst >= `RSISC_CONN_Q) && (cur.dst <= `RSISC_CONN_Q_END))
              q_nxt[cur.dst[3:0]] = res;
            else if ((cur.dst >= `RSISC_CONN_M) && (cur.dst <= `RSISC_CONN_M_END))
              m_nxt[5'(cur.dst - `RSISC_CONN_M)] = res;
          end
        end
      end
      rsisc_pkg::ST_UPDATE:
      begin
        // All outputs switch together once the program has run
        out_nxt    = q_r;
        aq_out_nxt = aq_r;
        pulse_nxt  = 1'b1;
        state_nxt  = rsisc_pkg::ST_SAMPLE;
      end
      default:
      begin
        state_nxt = rsisc_pkg::ST_STOP;
      end
    endcase
    if (stop_req && (state_r != rsisc_pkg::ST_STOP))
    begin
      state_nxt  = rsisc_pkg::ST_STOP;
      out_nxt    = `RSISC_OUT_RST;
      aq_out_nxt = '0;
      pulse_nxt  = 1'b0;
    end
    run_nxt = (state_nxt != rsisc_pkg::ST_STOP);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r   <= rsisc_pkg::ST_STOP;
      boot_r    <= 1'b1;
      run_r     <= 1'b0;
      pulse_r   <= 1'b0;
      idx_r     <= 6'h00;
      din_img_r <= 24'h00_0000;
      key_img_r <= 4'h0;
      ai_img_r  <= '0;
      out_r     <= `RSISC_OUT_RST;
      aq_out_r  <= '0;
      q_r       <= `RSISC_OUT_RST;
      m_r       <= `RSISC_FLAG_RST;
      s_r       <= `RSISC_SHIFT_RST;
      b_r       <= 32'h0000_0000;
      am_r      <= '0;
      aq_r      <= '0;
      prog_r    <= '0;
    end
    else
    begin
      state_r   <= state_nxt;
      boot_r    <= boot_nxt;
      run_r     <= run_nxt;
      pulse_r   <= pulse_nxt;
      idx_r     <= idx_nxt;
      din_img_r <= din_img_nxt;
      key_img_r <= key_img_nxt;
      ai_img_r  <= ai_img_nxt;
      out_r     <= out_nxt;
      aq_out_r  <= aq_out_nxt;
      q_r       <= q_nxt;
      m_r       <= m_nxt;
      s_r       <= s_nxt;
      b_r       <= b_nxt;
      am_r      <= am_nxt;
      aq_r      <= aq_nxt;
      prog_r    <= prog_nxt;
    end
  end

  assign field_out  = out_r;
  assign analog_out = aq_out_r;
  assign led_green  = run_r;
  assign led_red    = ~run_r;
  assign scan_pulse = pulse_r;

endmodule

`default_nettype wire

// [verification/rsisc_top_monitor.sv]
// Port checker for the run/stop scan controller
`timescale 1ns/10ps
`default_nettype none

module rsisc_top_monitor (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        rst,
  // Mode control
  input wire logic                        program_present,
  input wire logic                        start_req,
  input wire logic                        stop_req,
  input wire logic [5:0]                  prog_len,
  // Outputs
  input wire logic [15:0]                 field_out,
  input wire rsisc_pkg::rsisc_ana_t [1:0] analog_out,
  input wire logic                        led_red,
  input wire logic                        led_green,
  input wire logic                        scan_pulse
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_stop_outs_off: assert property (led_red |-> field_out == 16'h0000 && analog_out == '0)
    else $error("outputs active while stopped");
  a_led_one_hot: assert property (scan_pulse |-> led_green && !led_red)
    else $error("indicator not green while scanning");
  a_stop_wins: assert property (stop_req |=> led_red && field_out == 16'h0000)
    else $error("stop request not obeyed");
  a_no_scan_stop: assert property (led_red && $past(led_red) |-> !scan_pulse)
    else $error("scan completed while stopped");
  a_no_prog_stay: assert property (led_red && !program_present |=> led_red)
    else $error("ran without a stored program");
  a_start_taken: assert property (led_red && program_present && start_req && !stop_req |=> led_green)
    else $error("start request not taken");
  a_out_at_update: assert property (($changed(field_out) || $changed(analog_out)) && !led_red |-> scan_pulse)
    else $error("outputs changed outside update");
  a_pulse_single: assert property (scan_pulse |=> !scan_pulse)
    else $error("scan pulse longer than one cycle");
  a_short_scan: assert property (scan_pulse && prog_len == 6'h00 |=> !scan_pulse ##1 !scan_pulse ##1 (scan_pulse || led_red))
    else $error("empty scan not three cycles");
endmodule

bind rsisc_top rsisc_top_monitor i_mon (.core_clk(core_clk), .rst(rst), .program_present(program_present),
  .start_req(start_req), .stop_req(stop_req), .prog_len(prog_len), .field_out(field_out),
  .analog_out(analog_out), .led_red(led_red), .led_green(led_green), .scan_pulse(scan_pulse));

`default_nettype wire

// [verification/rsisc_field_model.sv]
// Field terminals and expansion module indication model
`timescale 1ns/10ps
`default_nettype none

module rsisc_field_model (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Levels asked for by the bench
  input  wire logic [27:0]                 set_pin,
  input  wire rsisc_pkg::rsisc_ana_t [7:0] set_ai,
  input  wire logic                        host_run,
  // Terminals seen by the base unit
  output logic [7:0]                       base_in_pin,
  output logic [15:0]                      exp_in_pin,
  output logic [3:0]                       cursor_key_pin,
  output rsisc_pkg::rsisc_ana_t [1:0]      base_ai,
  output rsisc_pkg::rsisc_ana_t [5:0]      exp_ai,
  // Module indication: 0 orange, 1 red, 2 green
  output logic [1:0]                       ind
);
  logic [3:0] init_cnt;

  // Terminal levels follow the bench one rising edge later, so the bench never races the model
  always @(posedge core_clk)
  begin
    {cursor_key_pin, exp_in_pin, base_in_pin} <= set_pin;
    {exp_ai, base_ai} <= set_ai;
    if (rst)
      init_cnt <= 4'h0;
    else if (init_cnt != 4'hF)
      init_cnt <= init_cnt + 4'h1;
  end

  assign ind = (init_cnt != 4'hF) ? 2'h0 : (host_run ? 2'h2 : 2'h1);
endmodule

`default_nettype wire

// [verification/run_stop_io_scan_control_tb.sv]
// Self-checking bench for the run/stop scan controller
`timescale 1ns/10ps
`default_nettype none

module run_stop_io_scan_control_tb;
  logic                        core_clk;
  logic                        rst;
  logic                        program_present;
  logic                        start_req;
  logic                        stop_req;
  logic                        prog_we;
  logic                        led_red;
  logic                        led_green;
  logic                        scan_pulse;
  logic [27:0]                 set_pin;
  logic [7:0]                  base_in_pin;
  logic [15:0]                 exp_in_pin;
  logic [15:0]                 field_out;
  logic [3:0]                  cursor_key_pin;
  logic [4:0]                  prog_addr;
  logic [5:0]                  prog_len;
  logic [1:0]                  ind;
  rsisc_pkg::rsisc_ana_t [7:0] set_ai;
  rsisc_pkg::rsisc_ana_t [1:0] base_ai;
  rsisc_pkg::rsisc_ana_t [1:0] analog_out;
  rsisc_pkg::rsisc_ana_t [5:0] exp_ai;
  rsisc_pkg::rsisc_blk_t       prog_word;
  int                          err_count = 0;
  int                          checks_done = 0;
  int                          cyc = 0;

  rsisc_field_model i_far (.core_clk(core_clk), .rst(rst), .set_pin(set_pin), .set_ai(set_ai),
    .host_run(led_green), .base_in_pin(base_in_pin), .exp_in_pin(exp_in_pin),
    .cursor_key_pin(cursor_key_pin), .base_ai(base_ai), .exp_ai(exp_ai), .ind(ind));

  rsisc_top i_dut (.core_clk(core_clk), .rst(rst), .base_in_pin(base_in_pin), .exp_in_pin(exp_in_pin),
    .cursor_key_pin(cursor_key_pin), .base_ai(base_ai), .exp_ai(exp_ai), .program_present(program_present),
    .start_req(start_req), .stop_req(stop_req), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_word(prog_word), .prog_len(prog_len), .field_out(field_out), .analog_out(analog_out),
    .led_red(led_red), .led_green(led_green), .scan_pulse(scan_pulse));

  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_pulses(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 500)
    begin
      @(posedge core_clk);
      #1;
      if (scan_pulse === 1'b1)
        n--;
      k++;
    end
    check(20'(n), 20'h0_0000, "scan count");
  endtask

  task automatic load(input logic [4:0] a, input rsisc_pkg::rsisc_op_t op, input logic [7:0] d, i0, i1);
    @(negedge core_clk);
    prog_we = 1'b1;
    prog_addr = a;
    prog_word = '{op, d, 8'h02, 8'h02, i1, i0};
    @(negedge core_clk);
    prog_we = 1'b0;
  endtask

  task automatic t_boot();
    check(20'(led_red), 20'h0_0001, "red in reset");
    check(20'(ind), 20'h0_0000, "module initialising");
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    check(20'(led_green), 20'h0_0001, "auto start");
    wait_pulses(3);
  endtask

  task automatic t_stop();
    logic bad;
    bad = 1'b0;
    @(negedge core_clk);
    stop_req = 1'b1;
    @(negedge core_clk);
    stop_req = 1'b0;
    check({3'h0, led_red, field_out}, 20'h1_0000, "stop state");
    set_pin = ~set_pin;
    repeat (40)
    begin
      @(posedge core_clk);
      #1;
      bad = bad | (scan_pulse !== 1'b0) | (field_out !== 16'h0000) | (analog_out !== '0);
    end
    check(20'(bad), 20'h0_0000, "activity in stop");
    check(20'(ind), 20'h0_0001, "module stopped");
  endtask

  task automatic t_refuse();
    @(negedge core_clk);
    program_present = 1'b0;
    start_req = 1'b1;
    repeat (5) @(negedge core_clk);
    start_req = 1'b0;
    check(20'(led_red), 20'h0_0001, "start without program");
  endtask

  task automatic run_case(input logic [27:0] p, input rsisc_pkg::rsisc_ana_t a0, a1, a7);
    logic [15:0] q;
    @(negedge core_clk);
    set_pin = p;
    set_ai = {a7, 50'h0, a1, a0};
    q = {4'h0, ~p[0], p[0], ~(p[0] & p[1]), p[24] ^ p[1], p[23], a0 > a1, p[8], p[7], 3'h3, p[0]};
    wait_pulses(3);
    check({4'h0, field_out}, {4'h0, q}, "field outputs");
    check(analog_out, {a7, a1}, "analog outputs");
    check(20'(ind), 20'h0_0002, "module running");
  endtask

  task automatic t_program();
    load(5'h00, rsisc_pkg::OP_AND, 8'h30, 8'h10, 8'h02);
    load(5'h01, rsisc_pkg::OP_OR, 8'h31, 8'h01, 8'h00);
    load(5'h02, rsisc_pkg::OP_NOR, 8'h32, 8'h00, 8'h02);
    load(5'h03, rsisc_pkg::OP_AND, 8'h33, 8'h01, 8'h00);
    load(5'h04, rsisc_pkg::OP_AND, 8'h34, 8'h17, 8'h02);
    load(5'h05, rsisc_pkg::OP_AND, 8'h35, 8'h18, 8'h02);
    load(5'h06, rsisc_pkg::OP_ACMP, 8'h36, 8'h00, 8'h01);
    load(5'h07, rsisc_pkg::OP_AMOV, 8'h08, 8'h01, 8'h02);
    load(5'h08, rsisc_pkg::OP_AND, 8'h37, 8'h27, 8'h02);
    load(5'h09, rsisc_pkg::OP_XOR, 8'h38, 8'h28, 8'h11);
    load(5'h0A, rsisc_pkg::OP_AMOV, 8'h09, 8'h07, 8'h02);
    load(5'h0B, rsisc_pkg::OP_NAND, 8'h39, 8'h10, 8'h11);
    load(5'h0C, rsisc_pkg::OP_NOT, 8'h40, 8'h80, 8'h02);
    load(5'h0D, rsisc_pkg::OP_SHIFT, 8'h60, 8'h10, 8'h01);
    load(5'h0E, rsisc_pkg::OP_AND, 8'h3A, 8'h58, 8'h02);
    load(5'h0F, rsisc_pkg::OP_AND, 8'h3B, 8'h40, 8'h02);
    prog_len = 6'h10;
    program_present = 1'b1;
    start_req = 1'b1;
    @(posedge core_clk);
    #1;
    check(20'(led_green), 20'h0_0001, "start");
    @(negedge core_clk);
    start_req = 1'b0;
    run_case(28'h100_0081, 10'h3FF, 10'h001, 10'h155);
    run_case(28'hEFF_FF7E, 10'h001, 10'h200, 10'h2AA);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Cuts a hung run short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    rst = 1'b1;
    set_pin = '0;
    set_ai = '0;
    program_present = 1'b1;
    start_req = 1'b0;
    stop_req = 1'b0;
    prog_we = 1'b0;
    prog_addr = 5'h00;
    prog_word = '0;
    prog_len = 6'h00;
    repeat (4) @(negedge core_clk);
    t_boot();
    t_stop();
    t_refuse();
    t_program();
    t_stop();
    wrap_up();
  end
endmodule

`default_nettype wire
